/* File: verilog/pwt_pkg.sv */
// shared constants, register offsets and carrier types of the pwm channel timer block
package pwt_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NUM_CH     = 8;
  localparam int NUM_PAIRS  = 4;
  localparam int ADDR_W     = 5;
  localparam int DATA_W     = 8;
  localparam int WIDE_W     = 16;

  // ****************************************************************
  // register offsets (one byte each)
  // ****************************************************************
  localparam logic [4:0] OFS_ENABLE   = 5'h00;  // channel_enable_bit per channel
  localparam logic [4:0] OFS_POLARITY = 5'h01;  // channel_polarity_bit per channel
  localparam logic [4:0] OFS_CLKSEL   = 5'h02;  // channel_clock_select_bit per channel
  localparam logic [4:0] OFS_ALIGN    = 5'h03;  // alignment_select_register
  localparam logic [4:0] OFS_CONTROL  = 5'h04;  // pwm_control_register
  localparam logic [4:0] OFS_COUNTER  = 5'h08;  // channel_counter 0..7 at 08..0F
  localparam logic [4:0] OFS_PERIOD   = 5'h10;  // channel_period_value 0..7 at 10..17
  localparam logic [4:0] OFS_DUTY     = 5'h18;  // channel_duty_value 0..7 at 18..1F

  // ****************************************************************
  // field positions of pwm_control_register (pair_join_bits)
  // ****************************************************************
  localparam int CTL_JOIN_ZERO_ONE  = 0;
  localparam int CTL_JOIN_TWO_THREE = 1;
  localparam int CTL_JOIN_FOUR_FIVE = 2;
  localparam int CTL_JOIN_SIX_SEVEN = 3;
  localparam int CTL_JOIN_W         = 4;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_DUTY   = 8'hFF;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  // one step of a counting engine
  typedef struct packed {
    logic [15:0] cnt;   // next counter value
    logic        down;  // next direction, high while counting down
    logic        load;  // effective period ends this step
  } pwt_step_s;

  // selected clock ticks from the prescaler
  typedef struct packed {
    logic a;
    logic sa;
    logic b;
    logic sb;
  } pwt_tick_s;

endpackage : pwt_pkg

/* File: verilog/pwt_channel_timer.sv */
// eight-channel pwm timer: counters, left/center alignment, pair joining, register port
`timescale 1ns/1ps

module pwt_channel_timer #(
  parameter int NUM_CH = pwt_pkg::NUM_CH
) (
  // clock, reset and freeze
  input  wire logic                        CLK,
  input  wire logic                        SRST,
  input  wire logic                        CE,
  // register port
  input  wire logic [pwt_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [pwt_pkg::DATA_W-1:0]  WDATA,
  input  wire logic                        WR_STB,
  input  wire logic                        RD_STB,
  output logic      [pwt_pkg::DATA_W-1:0]  RDATA,
  // selected clock ticks A, B and scaled SA, SB, one-cycle pulses on CLK
  input  wire pwt_pkg::pwt_tick_s          TICK,
  // channel_output_pin per channel
  output logic      [NUM_CH-1:0]           PWM_OUT
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [NUM_CH-1:0]              enable_q;
  logic [NUM_CH-1:0]              polarity_q;
  logic [NUM_CH-1:0]              clksel_q;
  logic [NUM_CH-1:0]              align_q;
  logic [pwt_pkg::CTL_JOIN_W-1:0] join_q;
  logic [7:0]                     cnt_q     [NUM_CH];
  logic                           down_q    [NUM_CH];
  logic [7:0]                     per_buf_q [NUM_CH];
  logic [7:0]                     dty_buf_q [NUM_CH];
  logic [7:0]                     per_act_q [NUM_CH];
  logic [7:0]                     dty_act_q [NUM_CH];

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // one counting step of a channel engine, 8-bit values zero-extended, 16-bit values for a joined pair
  function automatic pwt_pkg::pwt_step_s step_fn(
    input logic [15:0] cnt,
    input logic [15:0] per,
    input logic        down,
    input logic        center
  );
    pwt_pkg::pwt_step_s r;
    r.cnt  = cnt;
    r.down = down;
    r.load = 1'b0;
    if (per == 16'h0000) begin
      r.cnt  = 16'h0000;
      r.down = 1'b0;
      r.load = 1'b1;
    end else if (!center) begin
      r.down = 1'b0;
      if (cnt + 16'h0001 >= per) begin
        r.cnt  = 16'h0000;
        r.load = 1'b1;
      end else begin
        r.cnt  = cnt + 16'h0001;
      end
    end else if (!down) begin
      if (cnt + 16'h0001 >= per) begin
        r.cnt  = per;
        r.down = 1'b1;
      end else begin
        r.cnt  = cnt + 16'h0001;
      end
    end else begin
      if (cnt <= 16'h0001) begin
        r.cnt  = 16'h0000;
        r.down = 1'b0;
        r.load = 1'b1;
      end else begin
        r.cnt  = cnt - 16'h0001;
      end
    end
    return r;
  endfunction : step_fn

  // duty phase of the waveform: high while the first part of the cycle runs
  // going up it ends at the duty match, going down it restarts at the duty match
  function automatic logic active_fn(
    input logic [15:0] cnt,
    input logic [15:0] per,
    input logic [15:0] dty,
    input logic        down
  );
    logic a;
    a = 1'b0;
    if (per == 16'h0000) begin
      a = 1'b1;
    end else if (dty >= per) begin
      a = 1'b1;
    end else if (down) begin
      a = (cnt <= dty);
    end else begin
      a = (cnt < dty);
    end
    return a;
  endfunction : active_fn

  // clock source of a channel: A/SA for 0,1,4,5 and B/SB for 2,3,6,7
  function automatic logic tick_fn(
    input int                 ch,
    input logic               scaled,
    input pwt_pkg::pwt_tick_s t
  );
    logic r;
    if (ch[1] == 1'b0) begin
      r = scaled ? t.sa : t.a;
    end else begin
      r = scaled ? t.sb : t.b;
    end
    return r;
  endfunction : tick_fn

  // ****************************************************************
  // per-channel engine inputs and results
  // ****************************************************************
  logic                 joined_c  [NUM_CH];  // channel is part of a joined pair
  logic                 run_c     [NUM_CH];  // engine of this channel runs
  logic                 tick_c    [NUM_CH];
  logic                 cnt_wr_c  [NUM_CH];  // counter of this channel is cleared
  logic                 hold_c    [NUM_CH];  // values of this channel bypass the buffer
  logic [15:0]          cnt16_c   [NUM_CH];
  logic [15:0]          per16_c   [NUM_CH];
  logic [15:0]          dty16_c   [NUM_CH];
  logic                 down_c    [NUM_CH];
  logic                 center_c  [NUM_CH];
  pwt_pkg::pwt_step_s   step_c    [NUM_CH];
  logic                 active_c  [NUM_CH];
  logic                 wr_cnt_ch [NUM_CH];  // direct write to this counter byte

  // engine inputs: a joined pair runs on its odd channel with 16-bit values
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      wr_cnt_ch[c] = WR_STB && (ADDR == pwt_pkg::OFS_COUNTER + 5'(c));
    end
    for (int c = 0; c < NUM_CH; c++) begin
      joined_c[c] = join_q[c / 2];
      if (joined_c[c]) begin
        cnt16_c[c]  = {cnt_q[c & ~1], cnt_q[c | 1]};
        per16_c[c]  = {per_act_q[c & ~1], per_act_q[c | 1]};
        dty16_c[c]  = {dty_act_q[c & ~1], dty_act_q[c | 1]};
        down_c[c]   = down_q[c | 1];
        center_c[c] = align_q[c | 1];
        run_c[c]    = enable_q[c | 1];
        tick_c[c]   = tick_fn(c | 1, clksel_q[c | 1], TICK);
        cnt_wr_c[c] = wr_cnt_ch[c & ~1] || wr_cnt_ch[c | 1];
      end else begin
        cnt16_c[c]  = {8'h00, cnt_q[c]};
        per16_c[c]  = {8'h00, per_act_q[c]};
        dty16_c[c]  = {8'h00, dty_act_q[c]};
        down_c[c]   = down_q[c];
        center_c[c] = align_q[c];
        run_c[c]    = enable_q[c];
        tick_c[c]   = tick_fn(c, clksel_q[c], TICK);
        cnt_wr_c[c] = wr_cnt_ch[c];
      end
      step_c[c]   = step_fn(cnt16_c[c], per16_c[c], down_c[c], center_c[c]);
      active_c[c] = active_fn(cnt16_c[c], per16_c[c], dty16_c[c], down_c[c]);
      hold_c[c]   = !run_c[c];
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // alignment and join bits take effect at once; software keeps them stable
  // while a channel runs, otherwise one irregular cycle may appear
  always_ff @(posedge CLK) begin
    if (SRST) begin
      enable_q   <= '0;
      polarity_q <= '0;
      clksel_q   <= '0;
      align_q    <= '0;
      join_q     <= '0;
    end else if (CE && WR_STB) begin
      case (ADDR)
        pwt_pkg::OFS_ENABLE:   enable_q   <= WDATA;
        pwt_pkg::OFS_POLARITY: polarity_q <= WDATA;
        pwt_pkg::OFS_CLKSEL:   clksel_q   <= WDATA;
        pwt_pkg::OFS_ALIGN:    align_q    <= WDATA;
        pwt_pkg::OFS_CONTROL:  join_q     <= WDATA[pwt_pkg::CTL_JOIN_W-1:0];
        default:               ;
      endcase
    end
  end

  // ****************************************************************
  // counters and direction
  // ****************************************************************
  // both engines of a joined pair compute the same 16-bit step and each writes back its own byte,
  // so the carry between them is never split over two steps
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cnt_q[c]  <= pwt_pkg::RST_BYTE;
        down_q[c] <= 1'b0;
      end
    end else if (CE) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (cnt_wr_c[c]) begin
          cnt_q[c]  <= 8'h00;
          down_q[c] <= 1'b0;
        end else if (run_c[c] && tick_c[c]) begin
          if (joined_c[c]) begin
            cnt_q[c]  <= c[0] ? step_c[c].cnt[7:0] : step_c[c].cnt[15:8];
          end else begin
            cnt_q[c]  <= step_c[c].cnt[7:0];
          end
          down_q[c] <= step_c[c].down;
        end else if (per16_c[c] == 16'h0000) begin
          cnt_q[c]  <= 8'h00;
          down_q[c] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // period and duty, buffered and active
  // ****************************************************************
  // active values only change at period end, counter write or while
  // disabled, so a waveform is always wholly old or wholly new
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int c = 0; c < NUM_CH; c++) begin
        per_buf_q[c] <= pwt_pkg::RST_PERIOD;
        dty_buf_q[c] <= pwt_pkg::RST_DUTY;
        per_act_q[c] <= pwt_pkg::RST_PERIOD;
        dty_act_q[c] <= pwt_pkg::RST_DUTY;
      end
    end else if (CE) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (WR_STB && ADDR == pwt_pkg::OFS_PERIOD + 5'(c)) begin
          per_buf_q[c] <= WDATA;
        end
        if (WR_STB && ADDR == pwt_pkg::OFS_DUTY + 5'(c)) begin
          dty_buf_q[c] <= WDATA;
        end
        if (hold_c[c] || cnt_wr_c[c] ||
            (run_c[c] && tick_c[c] && step_c[c].load)) begin
          per_act_q[c] <= per_buf_q[c];
          dty_act_q[c] <= dty_buf_q[c];
          if (hold_c[c] && WR_STB && ADDR == pwt_pkg::OFS_PERIOD + 5'(c)) begin
            per_act_q[c] <= WDATA;
          end
          if (hold_c[c] && WR_STB && ADDR == pwt_pkg::OFS_DUTY + 5'(c)) begin
            dty_act_q[c] <= WDATA;
          end
        end
      end
    end
  end

  // ****************************************************************
  // output flip-flops
  // ****************************************************************
  // the pin follows the duty phase of the engine state one cycle later;
  // polarity one drives the duty phase high, polarity zero low
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PWM_OUT <= '0;
    end else if (CE) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!run_c[c] || (joined_c[c] && c[0] == 1'b0)) begin
          PWM_OUT[c] <= 1'b0;
        end else if (joined_c[c]) begin
          PWM_OUT[c] <= ~(active_c[c] ^ polarity_q[c | 1]);
        end else begin
          PWM_OUT[c] <= ~(active_c[c] ^ polarity_q[c]);
        end
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // reading a counter never disturbs it; period and duty read the buffer
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= '0;
      if (RD_STB) begin
        case (ADDR)
          pwt_pkg::OFS_ENABLE:   RDATA <= enable_q;
          pwt_pkg::OFS_POLARITY: RDATA <= polarity_q;
          pwt_pkg::OFS_CLKSEL:   RDATA <= clksel_q;
          pwt_pkg::OFS_ALIGN:    RDATA <= align_q;
          pwt_pkg::OFS_CONTROL:  RDATA <= {4'h0, join_q};
          default: begin
            if (ADDR >= pwt_pkg::OFS_DUTY) begin
              RDATA <= dty_buf_q[ADDR[2:0]];
            end else if (ADDR >= pwt_pkg::OFS_PERIOD) begin
              RDATA <= per_buf_q[ADDR[2:0]];
            end else if (ADDR >= pwt_pkg::OFS_COUNTER) begin
              RDATA <= cnt_q[ADDR[2:0]];
            end else begin
              RDATA <= 8'h00;
            end
          end
        endcase
      end
    end
  end

endmodule : pwt_channel_timer

/* File: test/pwt_channel_timer_chk.sv */
// checker of register port and output pin relations of the pwm channel timer
`timescale 1ns/1ps
module pwt_channel_timer_chk #(
  parameter int NUM_CH = pwt_pkg::NUM_CH
) (
  // clock and reset
  input wire logic                       CLK,
  input wire logic                       SRST,
  input wire logic                       CE,
  // register port
  input wire logic [pwt_pkg::ADDR_W-1:0] ADDR,
  input wire logic [pwt_pkg::DATA_W-1:0] WDATA,
  input wire logic                       WR_STB,
  input wire logic                       RD_STB,
  input wire logic [pwt_pkg::DATA_W-1:0] RDATA,
  // ticks and pins
  input wire pwt_pkg::pwt_tick_s         TICK,
  input wire logic [NUM_CH-1:0]          PWM_OUT
);
  // ****************************************************************
  // register mirror
  // ****************************************************************
  logic [7:0] mir_q [32];
  logic [7:0] exp_q;
  // counters are mirrored too but never compared, they move on their own
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < 32; i++)
        mir_q[i] <= (i < 16) ? pwt_pkg::RST_BYTE :
                    (i < 24) ? pwt_pkg::RST_PERIOD : pwt_pkg::RST_DUTY;
    end else if (CE && WR_STB) begin
      mir_q[ADDR] <= WDATA;
    end
  end
  // value a read should return, taken at the read edge
  always_ff @(posedge CLK) begin
    if (SRST)
      exp_q <= 8'h00;
    else if (CE && RD_STB)
      exp_q <= mir_q[ADDR];
  end
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  a_rdata_idle: assert property ($past(CE) && !$past(RD_STB) |-> RDATA == 8'h00)
    else $error("read data not zero outside a read answer");
  a_unmapped_zero: assert property (RD_STB && CE && ADDR inside {5'h05, 5'h06, 5'h07}
    |=> RDATA == 8'h00) else $error("unmapped read not zero");
  a_cfg_readback: assert property (RD_STB && CE && ADDR < 5'h04 |=> RDATA == exp_q)
    else $error("config byte read back wrong");
  a_ctl_readback: assert property (RD_STB && CE && ADDR == pwt_pkg::OFS_CONTROL
    |=> RDATA[3:0] == exp_q[3:0]) else $error("join bits read back wrong");
  a_buf_readback: assert property (RD_STB && CE && ADDR[4] |=> RDATA == exp_q)
    else $error("period or duty read back wrong");
  a_cnt_clear: assert property (WR_STB && CE && ADDR[4:3] == 2'b01 ##1 RD_STB && CE
    && ADDR == $past(ADDR) |=> RDATA == 8'h00) else $error("counter not cleared");
  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    a_disabled_low: assert property (!mir_q[0][n] && $past(!mir_q[0][n]) |-> !PWM_OUT[n])
      else $error("disabled channel drives its pin");
  end
  for (genvar k = 0; k < NUM_CH / 2; k++) begin : g_pair
    a_joined_even_low: assert property (mir_q[4][k] && $past(mir_q[4][k])
      |-> !PWM_OUT[2*k]) else $error("even pin of a joined pair active");
  end
  // main scenarios reached
  c_read: cover property (RD_STB ##1 RDATA != 8'h00);
  c_joined: cover property (mir_q[4][0] && PWM_OUT[1]);
  c_rise: cover property ($rose(PWM_OUT[0]));
endmodule : pwt_channel_timer_chk

bind pwt_channel_timer pwt_channel_timer_chk #(.NUM_CH(NUM_CH)) u_chk (
  .CLK(CLK), .SRST(SRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .RDATA(RDATA), .TICK(TICK), .PWM_OUT(PWM_OUT));

/* File: test/pwt_channel_timer_bench.sv */
// self-checking bench of the pwm channel timer
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module pwt_channel_timer_bench;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  logic               ce = 1'b1;
  logic [1:0]         ph = 2'h0;
  logic [7:0]         er;
  logic [31:0]        ew;
  logic [4:0]         addr = 5'h00;
  logic [7:0]         wdata = 8'h00;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic               rdv = 1'b0;
  logic               win = 1'b0;
  logic               winq = 1'b0;
  logic               prv = 1'b0;
  logic [2:0]         wch = 3'h0;
  pwt_pkg::pwt_tick_s tick = '0;
  wire  [7:0]         rdata;
  wire  [7:0]         pwm;
  logic [7:0]         rdq [$];
  logic [31:0]        wq [$];
  logic [31:0]        cs [13];
  int                 error_cnt = 0;
  int                 n_checks = 0;
  int                 hi = 0;
  int                 rises = 0;

  always #2 clk = ~clk;

  pwt_channel_timer #(.NUM_CH(8)) dut_u (
    .CLK(clk), .SRST(srst), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR_STB(wr),
    .RD_STB(rd), .RDATA(rdata), .TICK(tick), .PWM_OUT(pwm));

  // a ticks every cycle, b every other cycle, sa every third cycle, sb random;
  // sa stays regular so a scaled channel can be measured by counting
  always @(posedge clk) begin
    tick.a <= 1'b1;
    tick.b <= ~tick.b;
    tick.sa <= (ph == 2'h2);
    tick.sb <= 1'($urandom);
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
  end

  // ****************************************************************
  // watcher: read answers and windowed pin statistics
  // ****************************************************************
  always @(posedge clk) begin
    // pop once before comparing: the macro names its arguments twice
    if (rdv) begin
      er = rdq.pop_front();
      `CHK(rdata, er)
    end
    if (win) begin
      hi += int'(pwm[wch]);
      rises += int'(pwm[wch] && !prv);
    end
    if (winq && !win) begin
      ew = wq.pop_front();
      `CHK({16'(hi), 16'(rises)}, ew)
      hi = 0;
      rises = 0;
    end
    prv <= pwm[wch];
    rdv <= rd;
    winq <= win;
  end

  // a task never lowers its own strobe, so back-to-back calls assign once per step
  task automatic wr_r(input logic [4:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge clk);
  endtask : wr_r

  task automatic rd_r(input logic [4:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    wr <= 1'b0;
    rdq.push_back(e);
    @(posedge clk);
  endtask : rd_r

  task automatic idle(input int n);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask : idle

  // watch one pin for a whole number of periods and note the expected counts
  task automatic window(input int ch, input int w, input int h, input int r);
    wch <= 3'(ch);
    idle(2);
    win <= 1'b1;
    wq.push_back({16'(h), 16'(r)});
    idle(w);
    win <= 1'b0;
    idle(2);
  endtask : window

  // one 8-bit channel: set it up while disabled, clear, enable, measure
  task automatic meas(input int ch, input int p, input int d, input logic pol, al, sc);
    int m;
    int w;
    int h;
    m = (al ? 2 : 1) * (sc ? 3 : (ch[1] ? 2 : 1)); // b: every second cycle, sa: every third
    w = (p == 0) ? 64 : 8 * p * m;
    if (p == 0 || d >= p)
      h = pol ? w : 0;
    else if (d == 0)
      h = pol ? 0 : w;
    else
      h = 8 * m * (pol ? d : p - d);
    wr_r(pwt_pkg::OFS_ENABLE, 8'h00);
    wr_r(pwt_pkg::OFS_POLARITY, 8'(pol) << ch);
    wr_r(pwt_pkg::OFS_CLKSEL, 8'(sc) << ch);
    wr_r(pwt_pkg::OFS_ALIGN, 8'(al) << ch);
    wr_r(pwt_pkg::OFS_PERIOD + 5'(ch), 8'(p));
    wr_r(pwt_pkg::OFS_DUTY + 5'(ch), 8'(d));
    rd_r(pwt_pkg::OFS_PERIOD + 5'(ch), 8'(p));
    wr_r(pwt_pkg::OFS_COUNTER + 5'(ch), 8'($urandom));
    rd_r(pwt_pkg::OFS_COUNTER + 5'(ch), 8'h00);
    wr_r(pwt_pkg::OFS_ENABLE, 8'h01 << ch);
    idle(w + 8);
    window(ch, w, h, (p != 0 && d != 0 && d < p) ? 8 : 0);
    if (p == 0)
      rd_r(pwt_pkg::OFS_COUNTER + 5'(ch), 8'h00);
  endtask : meas

  task automatic finish_test;
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    // channel, period, duty, {scaled, polarity, center}
    cs = '{32'h00040100, 32'h00040102, 32'h00040101, 32'h00050203, 32'h00060002,
           32'h00060001, 32'h00030302, 32'h00030701, 32'h00000202, 32'h00000201,
           32'h03050200, 32'h06070303, 32'h04050106};
    void'($urandom(32'h6bbd5978));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // reset values and two unmapped places, one of them written
    rd_r(pwt_pkg::OFS_PERIOD, pwt_pkg::RST_PERIOD);
    rd_r(pwt_pkg::OFS_DUTY + 5'h07, pwt_pkg::RST_DUTY);
    rd_r(pwt_pkg::OFS_ENABLE, 8'h00);
    rd_r(5'h06, 8'h00);
    wr_r(5'h05, 8'h5A);
    rd_r(5'h05, 8'h00);
    foreach (cs[i])
      meas(int'(cs[i][31:24]), int'(cs[i][23:16]), int'(cs[i][15:8]), cs[i][1], cs[i][0],
           cs[i][2]);
    // random period, duty and mode on a channel clocked by a
    repeat (3) begin
      int p;
      p = 1 + int'($urandom % 20);
      meas(5, p, int'($urandom % (p + 2)), 1'($urandom), 1'($urandom), 1'b0);
    end
    // joined pair 0/1: period 0x0180, duty 0x0040, odd polarity high
    wr_r(pwt_pkg::OFS_ENABLE, 8'h00);
    wr_r(pwt_pkg::OFS_ALIGN, 8'h01);
    wr_r(pwt_pkg::OFS_CONTROL, 8'h01);
    wr_r(pwt_pkg::OFS_POLARITY, 8'h02);
    wr_r(pwt_pkg::OFS_PERIOD, 8'h01);
    wr_r(pwt_pkg::OFS_PERIOD + 5'h01, 8'h80);
    wr_r(pwt_pkg::OFS_DUTY, 8'h00);
    wr_r(pwt_pkg::OFS_DUTY + 5'h01, 8'h40);
    wr_r(pwt_pkg::OFS_COUNTER, 8'h33);
    rd_r(pwt_pkg::OFS_COUNTER + 5'h01, 8'h00);
    wr_r(pwt_pkg::OFS_ENABLE, 8'h01);
    idle(20);
    rd_r(pwt_pkg::OFS_COUNTER, 8'h00);
    rd_r(pwt_pkg::OFS_COUNTER + 5'h01, 8'h00);
    wr_r(pwt_pkg::OFS_ENABLE, 8'h03);
    idle(400);
    window(1, 768, 128, 2);
    // a write to the high byte must also clear the running low byte; one
    // tick later the low byte is 1 but the high byte is still 0
    wr_r(pwt_pkg::OFS_COUNTER, 8'hC3);
    rd_r(pwt_pkg::OFS_COUNTER + 5'h01, 8'h00);
    rd_r(pwt_pkg::OFS_COUNTER, 8'h00);
    // a write while frozen must not land
    ce <= 1'b0;
    wr_r(pwt_pkg::OFS_POLARITY, 8'hFF);
    ce <= 1'b1;
    rd_r(pwt_pkg::OFS_POLARITY, 8'h02);
    idle(4);
    finish_test();
  end

  // watchdog well beyond the longest expected run
  initial begin
    #(4 * 60000);
    error_cnt++;
    finish_test();
  end
endmodule : pwt_channel_timer_bench
